// ---- logic/pdw_pkg.sv ----
// package for the process data watchdog and fault response control
// assumes one 100 MHz clock; register access arrives as 16-bit holding registers
package pdw_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

   // holding register addresses
   localparam logic [15:0] ADDR_TIMEOUT = 16'h07d0;
   localparam logic [15:0] ADDR_RESPONSE = 16'h07d2;
   localparam logic [15:0] ADDR_REASON = 16'h07d4;
   localparam logic [15:0] ADDR_COMMAND = 16'h07d6;
   localparam logic [15:0] ADDR_STATUS = 16'h1f3c;
   localparam logic [15:0] ADDR_OUT_DATA = 16'h2328;

   // timeout limits in milliseconds
   localparam logic [15:0] TIMEOUT_OFF = 16'h0000;
   localparam logic [15:0] TIMEOUT_MIN_MS = 16'h00c8;
   localparam logic [15:0] TIMEOUT_MAX_MS = 16'hfde8;

   // fault response codes
   localparam logic [15:0] RESP_ALL_LOW = 16'h0000;
   localparam logic [15:0] RESP_ALL_HIGH = 16'h0001;
   localparam logic [15:0] RESP_HOLD = 16'h0002;

   // fault reason codes
   localparam logic [15:0] REASON_NONE = 16'h0000;
   localparam logic [15:0] REASON_XFER_TIMEOUT = 16'h0007;
   localparam logic [15:0] REASON_HOST_TIMEOUT = 16'h0008;
   localparam logic [15:0] REASON_USER = 16'h0009;
   localparam logic [15:0] REASON_CONN_ABORT = 16'h000a;
   localparam logic [15:0] REASON_INIT_ERROR = 16'h000b;
   localparam logic [15:0] REASON_WATCHDOG = 16'h000c;
   localparam logic [15:0] REASON_MODBUS_TIMEOUT = 16'h000d;

   // command word bit positions
   localparam int unsigned CMD_SET_FAIL_BIT = 4;
   localparam int unsigned CMD_ACK_FAIL_BIT = 5;
   localparam int unsigned CMD_CLR_WARN_BIT = 7;

   // status word bit positions
   localparam int unsigned STAT_ERROR_BIT = 0;
   localparam int unsigned STAT_FAIL_BIT = 1;

   // reset values
   localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
   localparam logic [15:0] RESPONSE_RESET = 16'h0000;
   localparam logic [7:0] OUT_DATA_RESET = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] data;
   } pdw_req_type;

   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] data;
   } pdw_resp_type;
endpackage

// ---- logic/pdw_watchdog_ctrl.sv ----
// process data watchdog, substitute-value outputs, fault reason, command and status words
// assumes register requests are one-cycle strobes synchronous to sys_clk
`timescale 1ns/1ps

// Function
// - timeout in ms, 200 to 65000 valid
// - zero timeout keeps the watchdog off until it is first armed
// - timeout register is writable and readable
// - fault drives outputs low, high or hold
// - response code written at its register
// - fault reason readable at its register
// - reason codes 7 to 13 name causes
// - command with several bits set is an error
// - command register is write-only
// - bits 4,5,7 set fail, acknowledge, clear warning
// - status bit 0 shows any error
// - status bit 1 shows link-fail active
// - output writes start and restart; reads never
// - missed trigger applies substitutes, sets link-fail
// - auto mode: next output write acknowledges
// - acknowledge restarts; watchdog cannot be stopped
module pdw_watchdog_ctrl
   import pdw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire pdw_req_type regReq,
   output pdw_resp_type regResp,
   input wire logic ackAuto,
   input wire logic diagActive,
   input wire logic ioWarnSet,
   input wire logic faultReq,
   input wire logic [15:0] faultCode,
   output logic [7:0] doOut,
   output logic netFail,
   output logic errorPresent
);
   logic [15:0] timeout_q, timeout_d;
   logic [15:0] response_q, response_d;
   logic [15:0] reason_q, reason_d;
   logic [15:0] period_q, period_d;
   logic [15:0] wdCount_q, wdCount_d;
   logic [16:0] tickCnt_q, tickCnt_d;
   logic [7:0] outData_q, outData_d;
   logic [7:0] doOut_q, doOut_d;
   logic armed_q, armed_d;
   logic netFail_q, netFail_d;
   logic ioWarn_q, ioWarn_d;
   logic errorPresent_q, errorPresent_d;
   pdw_resp_type resp_q, resp_d;
   logic tick;
   logic outWr;
   logic cmdWr;
   logic rdReq;

   assign tick = (tickCnt_q == 17'(TICK_CYCLES - 1));
   assign outWr = regReq.wr && (regReq.addr == ADDR_OUT_DATA);
   assign cmdWr = regReq.wr && (regReq.addr == ADDR_COMMAND);
   assign rdReq = regReq.rd && !regReq.wr;

   always_comb begin
      logic restart;
      logic [15:0] nextPeriod;
      restart = 1'b0;
      nextPeriod = (timeout_q != TIMEOUT_OFF) ? timeout_q : period_q;
      timeout_d = timeout_q;
      response_d = response_q;
      reason_d = reason_q;
      period_d = period_q;
      wdCount_d = wdCount_q;
      tickCnt_d = tick ? 17'h00000 : tickCnt_q + 17'h00001;
      outData_d = outData_q;
      armed_d = armed_q;
      netFail_d = netFail_q;
      ioWarn_d = ioWarn_q;
      resp_d = '0;

      if (regReq.wr) begin
         resp_d.ack = 1'b1;
         unique case (regReq.addr)
            ADDR_TIMEOUT: begin
               if (regReq.data == TIMEOUT_OFF ||
                   (regReq.data >= TIMEOUT_MIN_MS && regReq.data <= TIMEOUT_MAX_MS)) begin
                  timeout_d = regReq.data;
               end else begin
                  resp_d.err = 1'b1;
               end
            end
            ADDR_RESPONSE: begin
               if (regReq.data <= RESP_HOLD) begin
                  response_d = regReq.data;
               end else begin
                  resp_d.err = 1'b1;
               end
            end
            ADDR_COMMAND: begin
               if ($countones(regReq.data) > 1) begin
                  resp_d.err = 1'b1;
               end else if (regReq.data[CMD_ACK_FAIL_BIT]) begin
                  netFail_d = 1'b0;
                  restart = armed_q;
               end else if (regReq.data[CMD_CLR_WARN_BIT]) begin
                  ioWarn_d = 1'b0;
               end
               // other single bits fall through untouched
            end
            ADDR_OUT_DATA: begin
               outData_d = regReq.data[7:0];
               restart = armed_q || (timeout_q != TIMEOUT_OFF);
               if (netFail_q && ackAuto) begin
                  netFail_d = 1'b0;
               end
            end
            default: begin
               resp_d.err = 1'b1;
            end
         endcase
      end else if (regReq.rd) begin
         resp_d.ack = 1'b1;
         unique case (regReq.addr)
            ADDR_TIMEOUT: resp_d.data = timeout_q;
            ADDR_RESPONSE: resp_d.data = response_q;
            ADDR_REASON: resp_d.data = reason_q;
            ADDR_STATUS: begin
               resp_d.data = 16'h0000;
               resp_d.data[STAT_ERROR_BIT] = errorPresent_q;
               resp_d.data[STAT_FAIL_BIT] = netFail_q;
            end
            ADDR_OUT_DATA: resp_d.data = {8'h00, outData_q};
            default: resp_d.err = 1'b1;
         endcase
      end

      // once armed the timer keeps running even if the period is later zeroed
      if (restart) begin
         armed_d = 1'b1;
         period_d = nextPeriod;
         wdCount_d = nextPeriod;
         tickCnt_d = 17'h00000;
      end else if (armed_q && !netFail_q && tick) begin
         if (wdCount_q <= 16'h0001) begin
            netFail_d = 1'b1;
            reason_d = REASON_WATCHDOG;
         end else begin
            wdCount_d = wdCount_q - 16'h0001;
         end
      end

      // fault sources set last so a set beats a same-cycle acknowledge
      if (cmdWr && $countones(regReq.data) == 1 && regReq.data[CMD_SET_FAIL_BIT]) begin
         netFail_d = 1'b1;
         reason_d = REASON_USER;
      end
      if (faultReq) begin
         netFail_d = 1'b1;
         reason_d = faultCode;
      end
      if (ioWarnSet) begin
         ioWarn_d = 1'b1;
      end

      errorPresent_d = diagActive || ioWarn_q || netFail_q;
      if (netFail_q) begin
         unique case (response_q)
            RESP_ALL_HIGH: doOut_d = 8'hff;
            RESP_HOLD: doOut_d = doOut_q;
            default: doOut_d = 8'h00;
         endcase
      end else begin
         doOut_d = outData_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timeout_q <= TIMEOUT_RESET;
         response_q <= RESPONSE_RESET;
         reason_q <= REASON_NONE;
         period_q <= TIMEOUT_RESET;
         wdCount_q <= TIMEOUT_RESET;
         tickCnt_q <= 17'h00000;
         outData_q <= OUT_DATA_RESET;
         doOut_q <= OUT_DATA_RESET;
         armed_q <= 1'b0;
         netFail_q <= 1'b0;
         ioWarn_q <= 1'b0;
         errorPresent_q <= 1'b0;
         resp_q <= '0;
      end else begin
         timeout_q <= timeout_d;
         response_q <= response_d;
         reason_q <= reason_d;
         period_q <= period_d;
         wdCount_q <= wdCount_d;
         tickCnt_q <= tickCnt_d;
         outData_q <= outData_d;
         doOut_q <= doOut_d;
         armed_q <= armed_d;
         netFail_q <= netFail_d;
         ioWarn_q <= ioWarn_d;
         errorPresent_q <= errorPresent_d;
         resp_q <= resp_d;
      end
   end

   assign regResp = resp_q;
   assign doOut = doOut_q;
   assign netFail = netFail_q;
   assign errorPresent = errorPresent_q;

   AST_TIMEOUT_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
      (regReq.wr && regReq.addr == ADDR_TIMEOUT && regReq.data != TIMEOUT_OFF &&
       regReq.data < TIMEOUT_MIN_MS) |=> (regResp.err && timeout_q == $past(timeout_q)))
      else $error("out-of-range timeout accepted");
   AST_ZERO_NO_ARM: assert property (@(posedge sys_clk) disable iff (rst)
      (!armed_q && timeout_q == TIMEOUT_OFF) |=> !armed_q)
      else $error("watchdog armed with zero period");
   AST_TIMEOUT_READBACK: assert property (@(posedge sys_clk) disable iff (rst)
      (regReq.wr && regReq.addr == ADDR_TIMEOUT && regReq.data == TIMEOUT_MIN_MS) ##1
      !(regReq.wr && regReq.addr == ADDR_TIMEOUT) ##1
      (regReq.rd && !regReq.wr && regReq.addr == ADDR_TIMEOUT) |=> regResp.data == TIMEOUT_MIN_MS)
      else $error("timeout readback wrong");
   AST_FORCE_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
      (netFail_q && response_q != RESP_HOLD) |=>
      (doOut == (($past(response_q) == RESP_ALL_HIGH) ? 8'hff : 8'h00)))
      else $error("substitute level wrong");
   AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
      (netFail_q && response_q == RESP_HOLD) |=> $stable(doOut))
      else $error("outputs moved in hold mode");
   AST_CMD_MULTI: assert property (@(posedge sys_clk) disable iff (rst)
      (cmdWr && $countones(regReq.data) > 1) |=> regResp.err)
      else $error("multi-bit command not flagged");
   AST_CMD_NO_READ: assert property (@(posedge sys_clk) disable iff (rst)
      (rdReq && regReq.addr == ADDR_COMMAND) |=> (regResp.err && regResp.data == 16'h0000))
      else $error("command register readable");
   AST_STATUS: assert property (@(posedge sys_clk) disable iff (rst)
      (rdReq && regReq.addr == ADDR_STATUS) |=>
      (regResp.data == {14'h0000, $past(netFail_q), $past(errorPresent_q)}))
      else $error("status word wrong");
   AST_READ_NO_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
      (armed_q && !netFail_q && tick && wdCount_q > 16'h0001 && !regReq.wr) |=>
      (wdCount_q == $past(wdCount_q) - 16'h0001))
      else $error("watchdog count did not step");
   AST_EXPIRY: assert property (@(posedge sys_clk) disable iff (rst)
      (armed_q && !netFail_q && tick && wdCount_q == 16'h0001 && !regReq.wr && !faultReq) |=>
      (netFail_q && reason_q == REASON_WATCHDOG))
      else $error("expiry did not raise link-fail");
   AST_AUTO_ACK: assert property (@(posedge sys_clk) disable iff (rst)
      (netFail_q && ackAuto && outWr && !faultReq) |=> (!netFail_q && wdCount_q == period_q))
      else $error("auto acknowledge failed");
endmodule // pdw_watchdog_ctrl

// ---- tb/pdw_client_model.sv ----
// client model issuing holding register reads and writes
// assumes the bench calls xfer only after reset is released
`timescale 1ns/1ps
module pdw_client_model
   import pdw_pkg::*;
(
   input wire logic sys_clk,
   output pdw_req_type regReq,
   input wire pdw_resp_type regResp
);
   initial regReq = '0;
   // one-cycle strobe; released lines show inverted values, never stale ones
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
      output logic e, output logic [15:0] q, output logic ok);
      int n;
      ok = 1'b0;
      e = 1'b0;
      q = 16'h0000;
      @(posedge sys_clk);
      #1;
      regReq = '{wr: w, rd: !w, addr: a, data: d};
      @(posedge sys_clk);
      #1;
      regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
      for (n = 0; n < 4 && !ok; n++) begin
         if (regResp.ack === 1'b1) begin
            ok = 1'b1;
            e = regResp.err;
            q = regResp.data;
         end else begin
            @(posedge sys_clk);
            #1;
         end
      end
   endtask
endmodule // pdw_client_model

// ---- tb/testbench.sv ----
// self-checking bench for the process data watchdog block
// assumes the client model carries all register traffic
`timescale 1ns/1ps
module testbench;
   import pdw_pkg::*;
   typedef struct packed {
      logic w;
      logic [15:0] a;
      logic [15:0] d;
      logic e;
      logic [15:0] q;
   } pdw_row_type;
   localparam pdw_row_type ROWS [0:13] = '{
      '{1'b1, ADDR_TIMEOUT, 16'h00c7, 1'b1, 16'h0000},
      '{1'b1, ADDR_TIMEOUT, 16'hfde9, 1'b1, 16'h0000},
      '{1'b1, ADDR_TIMEOUT, 16'hfde8, 1'b0, 16'h0000},
      '{1'b0, ADDR_TIMEOUT, 16'h0000, 1'b0, 16'hfde8},
      '{1'b1, ADDR_RESPONSE, 16'h0003, 1'b1, 16'h0000},
      '{1'b1, ADDR_RESPONSE, 16'h0002, 1'b0, 16'h0000},
      '{1'b0, ADDR_RESPONSE, 16'h0000, 1'b0, 16'h0002},
      '{1'b0, ADDR_REASON, 16'h0000, 1'b0, 16'h0000},
      '{1'b0, ADDR_COMMAND, 16'h0000, 1'b1, 16'h0000},
      '{1'b1, ADDR_COMMAND, 16'h0030, 1'b1, 16'h0000},
      '{1'b1, ADDR_COMMAND, 16'h0001, 1'b0, 16'h0000},
      '{1'b0, ADDR_STATUS, 16'h0000, 1'b0, 16'h0000},
      '{1'b1, ADDR_STATUS, 16'h0001, 1'b1, 16'h0000},
      '{1'b0, 16'h0000, 16'h0000, 1'b1, 16'h0000}
   };
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ackAuto = 1'b0;
   logic diagActive = 1'b0;
   logic ioWarnSet = 1'b0;
   logic faultReq = 1'b0;
   logic [15:0] faultCode = 16'h0000;
   pdw_req_type regReq;
   pdw_resp_type regResp;
   logic [7:0] doOut;
   logic netFail;
   logic errorPresent;
   logic e;
   logic [15:0] q;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   int m;
   int t0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   // short tick keeps a 200 ms period at 800 cycles
   pdw_watchdog_ctrl #(.TICK_CYCLES(4)) i_pdw_watchdog_ctrl (.sys_clk(sys_clk), .rst(rst),
      .regReq(regReq), .regResp(regResp), .ackAuto(ackAuto), .diagActive(diagActive),
      .ioWarnSet(ioWarnSet), .faultReq(faultReq), .faultCode(faultCode), .doOut(doOut),
      .netFail(netFail), .errorPresent(errorPresent));
   pdw_client_model i_pdw_client_model (.sys_clk(sys_clk), .regReq(regReq),
      .regResp(regResp));
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      samples_checked++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic report_and_stop;
      $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic rw(input logic w, input logic [15:0] a, input logic [15:0] d);
      logic ok;
      i_pdw_client_model.xfer(w, a, d, e, q, ok);
      if (!ok) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      rw(1'b1, a, d);
      chk("write refused", 16'h0000, {15'h0000, e});
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] x);
      rw(1'b0, a, 16'h0000);
      chk("read data", x, q);
   endtask
   task automatic step;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_fail(input int lo, input int hi);
      int n;
      for (n = 0; n < 1000 && netFail !== 1'b1; n++) step();
      if (netFail !== 1'b1) begin
         miscompares++;
         report_and_stop();
      end
      chk("expiry in window", 16'h0001, {15'h0000, cyc - t0 >= lo && cyc - t0 <= hi});
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      foreach (ROWS[i]) begin
         rw(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         chk("row err", {15'h0000, ROWS[i].e}, {15'h0000, e});
         chk("row data", ROWS[i].q, q);
      end
      wr(ADDR_RESPONSE, RESP_ALL_HIGH);
      wr(ADDR_TIMEOUT, TIMEOUT_MIN_MS);
      rd(ADDR_TIMEOUT, TIMEOUT_MIN_MS);
      repeat (900) step();
      chk("unarmed", 16'h0000, {15'h0000, netFail});
      wr(ADDR_OUT_DATA, 16'h005a);
      t0 = cyc;
      repeat (20) rd(ADDR_TIMEOUT, TIMEOUT_MIN_MS);
      wait_fail(790, 810);
      step();
      chk("substitute", 16'h00ff, {8'h00, doOut});
      rd(ADDR_REASON, REASON_WATCHDOG);
      rd(ADDR_STATUS, 16'h0003);
      wr(ADDR_OUT_DATA, 16'h0033);
      rd(ADDR_STATUS, 16'h0003);
      wr(ADDR_TIMEOUT, TIMEOUT_OFF);
      wr(ADDR_COMMAND, 16'h0020);
      t0 = cyc;
      step();
      chk("after ack", 16'h0033, {8'h00, doOut});
      wait_fail(790, 810);
      for (m = 0; m < 3; m++) begin
         wr(ADDR_COMMAND, 16'h0020);
         wr(ADDR_RESPONSE, m[15:0]);
         wr(ADDR_OUT_DATA, 16'h0096);
         wr(ADDR_COMMAND, 16'h0010);
         step();
         chk("mode out", m == 0 ? 16'h0000 : m == 1 ? 16'h00ff : 16'h0096, {8'h00, doOut});
         rd(ADDR_REASON, REASON_USER);
      end
      ackAuto = 1'b1;
      wr(ADDR_OUT_DATA, 16'h003c);
      step();
      chk("auto ack", 16'h003c, {7'h00, netFail, doOut});
      for (m = 7; m <= 13; m++) begin
         faultCode = m[15:0];
         faultReq = 1'b1;
         step();
         faultReq = 1'b0;
         rd(ADDR_REASON, m[15:0]);
      end
      wr(ADDR_COMMAND, 16'h0020);
      repeat (2) step();
      chk("no error", 16'h0000, {15'h0000, errorPresent});
      diagActive = 1'b1;
      repeat (2) step();
      chk("diag error", 16'h0001, {15'h0000, errorPresent});
      diagActive = 1'b0;
      ioWarnSet = 1'b1;
      step();
      ioWarnSet = 1'b0;
      rd(ADDR_STATUS, 16'h0001);
      wr(ADDR_COMMAND, 16'h0080);
      step();
      rd(ADDR_STATUS, 16'h0000);
      rst = 1'b1;
      step();
      rst = 1'b0;
      chk("reset pins", 16'h0000, {7'h00, netFail, doOut});
      // zero period after reset: output writes must never arm the timer
      wr(ADDR_OUT_DATA, 16'h00a5);
      repeat (900) step();
      chk("zero period", 16'h00a5, {7'h00, netFail, doOut});
      rd(ADDR_TIMEOUT, TIMEOUT_RESET);
      rd(ADDR_RESPONSE, RESPONSE_RESET);
      report_and_stop();
   end
endmodule // testbench
